// ==== core/lpms_sequencer.sv ====
// Low-power mode sequencer: light sleep, deep stop and power-off standby.
// Assumes the core pulses a sleep request and its irq on the same clock; the other wake sources and pins are asynchronous.
module lpms_sequencer
    import lpms_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // AHB-Lite slave
    input  wire logic                     hsel_i,
    input  wire logic [31:0]              haddr_i,
    input  wire logic [1:0]               htrans_i,
    input  wire logic                     hwrite_i,
    input  wire logic [2:0]               hsize_i,
    input  wire logic [31:0]              hwdata_i,
    input  wire logic                     hready_i,
    output logic      [31:0]              hrdata_o,
    output logic                          hreadyout_o,
    output logic                          hresp_o,
    // Processor side, same clock
    input  wire logic                     sleep_req_i,
    input  wire logic                     irq_event_i,
    // Asynchronous wake sources and straps
    input  wire logic [NUM_EXT_LINES-1:0] external_event_lines_i,
    input  wire logic                     supply_threshold_detector_i,
    input  wire logic                     rtc_event_i,
    input  wire logic                     usb_wakeup_i,
    input  wire logic                     eth_wakeup_i,
    input  wire logic                     wakeup_pin_i,
    input  wire logic                     independent_watchdog_timer_rst_i,
    input  wire logic                     external_reset_pin_n_i,
    input  wire logic                     regulator_bypass_i,
    // Power and clock controls
    output logic                          cpu_clk_en_o,
    output logic                          core_clk_en_o,
    output logic                          pll_en_o,
    output logic                          internal_rc_oscillator_en_o,
    output logic                          external_crystal_oscillator_en_o,
    output logic                          main_regulator_en_o,
    output logic                          low_power_regulator_en_o,
    output logic                          under_drive_o,
    output logic                          core_power_en_o,
    output logic                          backup_sram_retain_o,
    output logic                          sys_reset_o,
    output logic      [2:0]               state_o
);

    // ============================================================
    // Input synchronisers
    logic [SYNC_W-1:0] sync_s;

    lpms_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   ({regulator_bypass_i, external_reset_pin_n_i,
                     independent_watchdog_timer_rst_i, wakeup_pin_i,
                     eth_wakeup_i, usb_wakeup_i, rtc_event_i,
                     supply_threshold_detector_i, external_event_lines_i}),
        .sync_o    (sync_s)
    );

    // ============================================================
    // Register file and bus state
    logic [CTRL_W-1:0] ctrl_q,      ctrl_d;
    logic [WAKE_W-1:0] wake_mask_q, wake_mask_d;
    logic              sbf_q,       sbf_d;
    logic              ref_q,       ref_d;
    logic              wr_pend_q,   wr_pend_d;
    logic [3:0]        wr_ofs_q,    wr_ofs_d;
    logic [31:0]       hrdata_q,    hrdata_d;
    logic              hready_q;

    lpms_state_t       state_q,     state_d;
    logic [7:0]        rst_cnt_q,   rst_cnt_d;
    logic              wake_prev_q;

    logic              addr_phase;
    logic              mapped;
    logic              stop_wake;
    logic              stby_exit;
    logic              enter_sleep;
    lpms_mode_t        req_mode;

    assign addr_phase = hsel_i && hready_i && htrans_i[1];
    assign mapped     = (haddr_i[31:4] == 28'h0000000) && (haddr_i[1:0] == 2'h0);
    assign req_mode   = lpms_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign enter_sleep = (state_q == ST_RUN) && sleep_req_i;

    // Any enabled event line ends deep stop
    assign stop_wake  = |(sync_s[WAKE_W-1:0] & wake_mask_q);
    // Standby ends on reset pin, watchdog, wakeup rising edge or RTC
    assign stby_exit  = !sync_s[IN_RST_PIN_N] || sync_s[IN_WDOG] ||
                        (sync_s[IN_WAKE_PIN] && !wake_prev_q) || sync_s[EV_RTC];

    // ============================================================
    // Bus and register next values; a write lands in the data phase
    always_comb begin
        ctrl_d      = ctrl_q;
        wake_mask_d = wake_mask_q;
        sbf_d       = sbf_q;
        ref_d       = ref_q;
        wr_pend_d   = addr_phase && hwrite_i && mapped;
        wr_ofs_d    = addr_phase ? haddr_i[3:0] : wr_ofs_q;
        hrdata_d    = hrdata_q;
        if (addr_phase && !hwrite_i) begin
            unique case (haddr_i[3:0])
                CTRL_OFS:      hrdata_d = {27'h0000000, ctrl_q};
                WAKE_MASK_OFS: hrdata_d = {12'h000, wake_mask_q};
                STATUS_OFS:    hrdata_d = {27'h0000000, ref_q, sbf_q, state_q};
                default:       hrdata_d = 32'h00000000;   // Unmapped reads as zero
            endcase
            if (!mapped) begin
                hrdata_d = 32'h00000000;
            end
        end
        if (wr_pend_q) begin
            unique case (wr_ofs_q)
                CTRL_OFS:      ctrl_d      = hwdata_i[CTRL_W-1:0];
                WAKE_MASK_OFS: wake_mask_d = hwdata_i[WAKE_W-1:0];
                STATUS_OFS: begin
                    // Write one clears the sticky flags
                    if (hwdata_i[STAT_SBF_BIT]) sbf_d = 1'b0;
                    if (hwdata_i[STAT_REF_BIT]) ref_d = 1'b0;
                end
                default: ;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        if (enter_sleep && req_mode == MODE_STANDBY && sync_s[IN_BYPASS]) begin
            ref_d = 1'b1;
        end
        if (state_q == ST_STANDBY && stby_exit) begin
            sbf_d = 1'b1;
        end
        // Volatile control is lost over standby; restart brings back defaults
        if (state_q == ST_RESTART || (state_q == ST_STANDBY && stby_exit)) begin
            ctrl_d      = CTRL_RST;
            wake_mask_d = WAKE_MASK_RST;
        end
    end

    // Bus and register flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q      <= CTRL_RST;
            wake_mask_q <= WAKE_MASK_RST;
            sbf_q       <= 1'b0;
            ref_q       <= 1'b0;
            wr_pend_q   <= 1'b0;
            wr_ofs_q    <= 4'h0;
            hrdata_q    <= 32'h00000000;
            hready_q    <= 1'b1;
        end else if (ce_i) begin
            ctrl_q      <= ctrl_d;
            wake_mask_q <= wake_mask_d;
            sbf_q       <= sbf_d;
            ref_q       <= ref_d;
            wr_pend_q   <= wr_pend_d;
            wr_ofs_q    <= wr_ofs_d;
            hrdata_q    <= hrdata_d;
            hready_q    <= 1'b1;
        end
    end

    // Zero wait states and OKAY only, so the response is a constant register
    assign hrdata_o    = hrdata_q;
    assign hreadyout_o = hready_q;

    // ============================================================
    // Mode state machine
    always_comb begin
        state_d   = state_q;
        rst_cnt_d = rst_cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (sleep_req_i) begin
                    unique case (req_mode)
                        MODE_STOP:    state_d = ST_STOP;
                        // A bypassed regulator cannot be switched off: fall to stop
                        MODE_STANDBY: state_d = sync_s[IN_BYPASS] ? ST_STOP : ST_STANDBY;
                        default:      state_d = ST_SLEEP;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (irq_event_i) state_d = ST_RUN;
            end
            ST_STOP: begin
                if (stop_wake) state_d = ST_RUN;
            end
            ST_STANDBY: begin
                if (stby_exit) begin
                    state_d   = ST_RESTART;
                    rst_cnt_d = 8'h00;
                end
            end
            ST_RESTART: begin
                rst_cnt_d = rst_cnt_q + 8'h01;
                if (rst_cnt_q == RESTART_LAST) state_d = ST_RUN;
            end
            default: state_d = ST_RESTART;   // Illegal code recovers by restart
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q     <= ST_RUN;
            rst_cnt_q   <= 8'h00;
            wake_prev_q <= 1'b0;
        end else if (ce_i) begin
            state_q     <= state_d;
            rst_cnt_q   <= rst_cnt_d;
            wake_prev_q <= sync_s[IN_WAKE_PIN];
        end
    end

    // ============================================================
    // Power and clock controls, registered from the next state
    logic [11:0] ctl_q, ctl_d;   // Order matches the output list below

    always_comb begin
        // Run defaults: clocks, oscillators, main regulator and core power on
        ctl_d = CTL_RUN;
        unique case (state_d)
            ST_SLEEP:   ctl_d[0] = 1'b0;
            ST_STOP: begin
                ctl_d[4:0] = 5'h00;
                ctl_d[5]   = !ctrl_q[CTRL_LOWREG_BIT];
                ctl_d[6]   = ctrl_q[CTRL_LOWREG_BIT];
                ctl_d[7]   = ctrl_q[CTRL_UD_BIT];
                // Core stays powered so memory and registers hold
                ctl_d[8]   = 1'b1;
            end
            ST_STANDBY: begin
                ctl_d[8:0] = 9'h000;
                ctl_d[9]   = ctrl_q[CTRL_BKP_BIT];
            end
            ST_RESTART: ctl_d[10] = 1'b1;
            default: ;
        endcase
        ctl_d[11] = 1'b0;   // Bus response stays OKAY
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctl_q <= CTL_RUN;
        end else if (ce_i) begin
            ctl_q <= ctl_d;
        end
    end

    assign cpu_clk_en_o                     = ctl_q[0];
    assign core_clk_en_o                    = ctl_q[1];
    assign pll_en_o                         = ctl_q[2];
    assign internal_rc_oscillator_en_o      = ctl_q[3];
    assign external_crystal_oscillator_en_o = ctl_q[4];
    assign main_regulator_en_o              = ctl_q[5];
    assign low_power_regulator_en_o         = ctl_q[6];
    assign under_drive_o                    = ctl_q[7];
    assign core_power_en_o                  = ctl_q[8];
    assign backup_sram_retain_o             = ctl_q[9];
    assign sys_reset_o                      = ctl_q[10];
    assign state_o                          = state_q;
    assign hresp_o                          = ctl_q[11];

    // ============================================================
    // Checks
    property p_sleep_cpu_only;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_SLEEP |-> !cpu_clk_en_o && core_clk_en_o && pll_en_o && core_power_en_o;
    endproperty
    a_sleep_cpu_only: assert property (p_sleep_cpu_only) else $error("sleep clocks wrong");

    property p_sleep_wake;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_SLEEP && irq_event_i && ce_i |=> state_q == ST_RUN && cpu_clk_en_o;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

    property p_stop_clocks;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STOP |-> !core_clk_en_o && !pll_en_o && !internal_rc_oscillator_en_o
                               && !external_crystal_oscillator_en_o;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("stop clocks running");

    property p_stop_retain;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STOP |-> core_power_en_o && !sys_reset_o;
    endproperty
    a_stop_retain: assert property (p_stop_retain) else $error("stop lost power");

    property p_stop_regulator;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STOP |-> low_power_regulator_en_o == ctrl_q[CTRL_LOWREG_BIT]
                               && main_regulator_en_o != low_power_regulator_en_o;
    endproperty
    a_stop_regulator: assert property (p_stop_regulator) else $error("regulator choice wrong");

    property p_stop_underdrive;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q != ST_STOP |-> !under_drive_o;
    endproperty
    a_stop_underdrive: assert property (p_stop_underdrive) else $error("under-drive outside stop");

    property p_stop_wake;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STOP && stop_wake && ce_i |=> state_q == ST_RUN && core_clk_en_o;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop did not wake");

    property p_standby_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STANDBY |-> !core_power_en_o && !main_regulator_en_o && !pll_en_o
                                  && !internal_rc_oscillator_en_o;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("standby left power on");

    property p_standby_backup;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_STANDBY |-> backup_sram_retain_o == ctrl_q[CTRL_BKP_BIT];
    endproperty
    a_standby_backup: assert property (p_standby_backup) else $error("backup retain wrong");

    sequence s_standby_exit;
        state_q == ST_STANDBY && stby_exit && ce_i;
    endsequence
    sequence s_restart_begin;
        state_q == ST_RESTART && sys_reset_o && sbf_q && ctrl_q == CTRL_RST;
    endsequence
    property p_standby_exit;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_standby_exit |=> s_restart_begin ##0 (state_q == ST_RESTART)[*2];
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby exit wrong");

    property p_bypass_refuse;
        @(posedge clk_sys_i) disable iff (rst_i)
        enter_sleep && ce_i && req_mode == MODE_STANDBY && sync_s[IN_BYPASS]
        |=> state_q == ST_STOP && ref_q;
    endproperty
    a_bypass_refuse: assert property (p_bypass_refuse) else $error("standby not refused");

    property p_restart_run;
        @(posedge clk_sys_i) disable iff (rst_i)
        $rose(sys_reset_o) && ce_i |-> ##[1:60] (state_q == ST_RUN && !sys_reset_o);
    endproperty
    a_restart_run: assert property (p_restart_run) else $error("restart did not finish");

endmodule

// ==== core/lpms_pkg.sv ====
// Constants, register map and state codes of the low-power mode sequencer.
// Assumes one 50 MHz clock, synchronous active-high reset, AHB-Lite register access.
package lpms_pkg;

    // ============================================================
    // Register map (byte addresses)
    localparam logic [3:0]  CTRL_OFS        = 4'h0;
    localparam logic [3:0]  WAKE_MASK_OFS   = 4'h4;
    localparam logic [3:0]  STATUS_OFS      = 4'h8;

    // CTRL fields
    localparam int unsigned CTRL_MODE_LSB   = 0;   // Two bits: requested low-power mode
    localparam int unsigned CTRL_LOWREG_BIT = 2;   // Use low-power regulator in stop
    localparam int unsigned CTRL_UD_BIT     = 3;   // Under-drive in stop
    localparam int unsigned CTRL_BKP_BIT    = 4;   // Keep backup SRAM through standby
    localparam int unsigned CTRL_W          = 5;
    localparam logic [4:0]  CTRL_RST        = 5'h00;

    // Power control word in run, bit order as the sequencer outputs
    localparam logic [11:0] CTL_RUN         = 12'h13F;

    // STATUS fields
    localparam int unsigned STAT_STATE_LSB  = 0;   // Three bits: current state
    localparam int unsigned STAT_SBF_BIT    = 3;   // Woke from standby (write 1 clears)
    localparam int unsigned STAT_REF_BIT    = 4;   // Standby refused (write 1 clears)

    // Wake event vector positions and synchronised input vector
    localparam int unsigned NUM_EXT_LINES   = 16;
    localparam int unsigned EV_SUPPLY       = 16;
    localparam int unsigned EV_RTC          = 17;
    localparam int unsigned EV_USB          = 18;
    localparam int unsigned EV_ETH          = 19;
    localparam int unsigned WAKE_W          = 20;
    localparam logic [19:0] WAKE_MASK_RST   = 20'hFFFFF;
    localparam int unsigned IN_WAKE_PIN     = 20;
    localparam int unsigned IN_WDOG         = 21;
    localparam int unsigned IN_RST_PIN_N    = 22;
    localparam int unsigned IN_BYPASS       = 23;
    localparam int unsigned SYNC_W          = 24;

    // Restart hold time after leaving standby
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned RESTART_NS      = 1000;
    localparam int unsigned RESTART_CYCLES  = (RESTART_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  RESTART_LAST    = 8'(RESTART_CYCLES - 1);

    // ============================================================
    // Modes and states
    typedef enum logic [1:0] {
        MODE_SLEEP   = 2'h0,
        MODE_STOP    = 2'h1,
        MODE_STANDBY = 2'h2,
        MODE_RSVD    = 2'h3
    } lpms_mode_t;

    typedef enum logic [2:0] {
        ST_RUN      = 3'h0,
        ST_SLEEP    = 3'h1,
        ST_STOP     = 3'h2,
        ST_STANDBY  = 3'h3,
        ST_RESTART  = 3'h4
    } lpms_state_t;

endpackage

// ==== core/lpms_sync.sv ====
// Two-stage synchroniser bank for pins and foreign-domain levels.
// Assumes a single clock; the clock enable freezes both stages.
module lpms_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // ============================================================
    // Per-bit synchroniser; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_q;
            logic meta_d;
            logic sync_q;
            logic sync_d;

            // Next values, held while the clock enable is low
            always_comb begin
                meta_d = ce_i ? async_i[g] : meta_q;
                sync_d = ce_i ? meta_q : sync_q;
            end

            // Stages
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                end
            end

            assign sync_o[g] = sync_q;
        end
    endgenerate

endmodule

// ==== tb/lpms_partner.sv ====
// Partner model: the core's interrupt line and the on-chip wake sources.
// Assumes the bench arms one source at a time; pins are driven from clk_sys_i.
module lpms_partner
    import lpms_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        go_i,
    input  wire logic [4:0]  sel_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic [2:0]  state_i,
    output logic      [23:0] src_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q   = 4'h0;
    logic       armed_q = 1'b0;
    logic [4:0] sel_q   = 5'h00;
    // ==========================================
    // Source sequencing
    // A source stays up until the sequencer leaves its low-power state; a
    // short pulse could be lost in the synchroniser, so the model never pulses
    initial src_o = 24'h000000;
    always @(posedge clk_sys_i) begin
        if (go_i) begin
            armed_q <= 1'b1;
            cnt_q   <= dly_i;
            sel_q   <= sel_i;
        end else if (armed_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (armed_q) begin
            src_o[sel_q] <= 1'b1;
            armed_q      <= 1'b0;
        end else if (state_i == ST_RUN || state_i == ST_RESTART) begin
            src_o <= 24'h000000;
        end
    end
endmodule

// ==== tb/lpms_sequencer_tb_top.sv ====
// Self-checking bench of the low-power mode sequencer.
// Assumes AHB-Lite with a single slave whose hreadyout is the bus hready.
module lpms_sequencer_tb_top
    import lpms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 0, rst_i = 1, hsel = 0, hwrite = 0, sleep_req = 0, bypass = 0;
    logic        go = 0, hrdy, hresp, cpu, core, pll, rc, xt, mrg, lrg, ud, pwr, ret, sysr;
    logic        ce = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rdata;
    logic [1:0]  htrans = 0;
    logic [4:0]  sel = 0, c;
    logic [3:0]  dly = 0;
    logic [2:0]  st;
    logic [23:0] src;
    logic [9:0]  outs;
    int          seed = 89202, mismatches = 0, comparisons = 0, cyc = 0;
    assign outs = {cpu, core, pll, rc, xt, mrg, lrg, ud, pwr, ret};
    initial forever #10 clk_sys_i = ~clk_sys_i;
    lpms_sequencer i_lpms_sequencer (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .sleep_req_i(sleep_req), .irq_event_i(src[23]),
        .external_event_lines_i(src[15:0]), .supply_threshold_detector_i(src[16]),
        .rtc_event_i(src[17]), .usb_wakeup_i(src[18]), .eth_wakeup_i(src[19]),
        .wakeup_pin_i(src[20]), .independent_watchdog_timer_rst_i(src[21]),
        .external_reset_pin_n_i(~src[22]), .regulator_bypass_i(bypass), .cpu_clk_en_o(cpu),
        .core_clk_en_o(core), .pll_en_o(pll), .internal_rc_oscillator_en_o(rc),
        .external_crystal_oscillator_en_o(xt), .main_regulator_en_o(mrg),
        .low_power_regulator_en_o(lrg), .under_drive_o(ud), .core_power_en_o(pwr),
        .backup_sram_retain_o(ret), .sys_reset_o(sysr), .state_o(st));
    lpms_partner i_lpms_partner (.clk_sys_i(clk_sys_i), .go_i(go), .sel_i(sel), .dly_i(dly),
        .state_i(st), .src_o(src));
    // ==========================================
    // Expected enables: cpu, core, pll, rc, xtal, main, lowpwr, ud, power, retain
    function automatic logic [9:0] exp_out(input logic [2:0] s, input logic [4:0] k);
        case (s)
            ST_SLEEP: return 10'h1F2;
            ST_STOP: return {5'h00, ~k[2], k[2], k[3], 2'h2};
            ST_STANDBY: return {9'h000, k[4]};
            default: return 10'h3F2;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single transfer: hold each phase until hready is seen high at an edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        rdata = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int n = 0; n < 300 && st !== s; n++) @(negedge clk_sys_i);
        chk(32'(st), 32'(s));
    endtask
    // Program the mode, then pulse the core's request for one cycle
    task automatic enter(input logic [4:0] k);
        bus(1'b1, 32'h0, 32'(k));
        @(posedge clk_sys_i);
        sleep_req <= 1'b1;
        @(posedge clk_sys_i);
        sleep_req <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic wake(input logic [4:0] s);
        @(posedge clk_sys_i);
        go <= 1'b1;
        sel <= s;
        dly <= 4'($random(seed));
        @(posedge clk_sys_i);
        go <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(32'(outs), 32'(exp_out(ST_RUN, 5'h00)));
        rd_chk(32'h4, 32'h000FFFFF);
        rd_chk(32'h10, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("reset test done");
        // Both sleep encodings, irq ends each
        for (int i = 0; i < 2; i++) begin
            c = {3'($random(seed)), i[0], i[0]};
            enter(c);
            chk(32'(outs), 32'(exp_out(ST_SLEEP, c)));
            wake(5'd23);
            wait_st(ST_RUN);
        end
        $display("sleep test done");
        // Stop with random regulator settings; sources spread from line 0 to eth
        for (int i = 0; i < 8; i++) begin
            c = {3'($random(seed)), 2'h1};
            enter(c);
            chk(32'(st), 32'(ST_STOP));
            chk(32'(outs), 32'(exp_out(ST_STOP, c)));
            wake(5'(i * 19 / 7));
            wait_st(ST_RUN);
        end
        $display("stop test done");
        // Standby left by wakeup pin, watchdog, reset pin and RTC
        for (int i = 0; i < 4; i++) begin
            c = {3'($random(seed)), 2'h2};
            enter(c);
            chk(32'(outs), 32'(exp_out(ST_STANDBY, c)));
            wake(i == 3 ? 5'd17 : 5'(20 + i));
            wait_st(ST_RESTART);
            chk(32'(sysr), 32'h1);
            wait_st(ST_RUN);
            rd_chk(32'h0, 32'h0);
            rd_chk(32'h8, 32'h8);
            bus(1'b1, 32'h8, 32'h8);
        end
        $display("standby test done");
        // Bypassed regulator: standby refused, stop instead
        bypass <= 1'b1;
        enter(5'h02);
        chk(32'(st), 32'(ST_STOP));
        rd_chk(32'h8, 32'h12);
        // Frozen by the clock enable, a raised line must not end stop
        ce <= 1'b0;
        wake(5'd0);
        repeat (20) @(negedge clk_sys_i);
        chk(32'(st), 32'(ST_STOP));
        @(posedge clk_sys_i);
        ce <= 1'b1;
        wait_st(ST_RUN);
        @(posedge clk_sys_i);
        bypass <= 1'b0;
        bus(1'b1, 32'h8, 32'h10);
        rd_chk(32'h8, 32'h0);
        $display("bypass test done");
        end_of_test();
    end
endmodule
